// [common/cps_defs.svh]
// Purpose: constants for core power state signalling
// Assumes: status and debug control words are 32 bits wide
// Notes:   positions, reset values and the wake irq width only
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH
`define CPS_RP_POS      27
`define CPS_EXL_POS     1
`define CPS_ERL_POS     2
`define CPS_DM_POS      30
`define CPS_STATUS_RST  32'h0040_0004
`define CPS_DEBUG_RST   32'h0000_0000
`define CPS_INT_W       6
`endif

// [common/cps_pkg.sv]
// Purpose: types for core power state signalling
// Assumes: cps_defs.svh holds the numbers
// Notes:   types only
`include "cps_defs.svh"
package cps_pkg;
  typedef enum logic [1:0] {
    CPS_RUN   = 2'b01,
    CPS_SLEEP = 2'b10
  } cps_mode_t;

  typedef struct packed {
    logic low_power_request_out;
    logic exception_level_out;
    logic error_level_out;
    logic debug_mode_out;
  } cps_pwr_t;

  typedef struct packed {
    logic [`CPS_INT_W-1:0] irq;
    logic                  nmi;
  } cps_wake_t;

  typedef struct packed {
    cps_mode_t   mode;
    logic [31:0] status;
    logic [31:0] debug;
    logic [2:0]  irq_s1;
    logic [2:0]  irq_s2;
    logic [2:0]  irq_s3;
  } cps_state_t;
endpackage : cps_pkg

// [core/cps_core.sv]
// Purpose: power state outputs and wait sleep control
// Assumes: reset inputs already merged into arst_n_i
// Notes:   status and debug words written by the core pipeline
`timescale 1ns/1ps
`include "cps_defs.svh"
module cps_core (
  input  wire logic             clk_sys_i,
  input  wire logic             arst_n_i,
  input  wire logic             status_we_i,
  input  wire logic [31:0]      status_wdata_i,
  input  wire logic             debug_we_i,
  input  wire logic [31:0]      debug_wdata_i,
  input  wire logic             take_exl_i,
  input  wire logic             take_erl_i,
  input  wire logic             take_dbg_i,
  input  wire logic             wait_exec_i,
  input  wire cps_pkg::cps_wake_t wake_i,
  input  wire logic             soft_reset_i,
  output cps_pkg::cps_pwr_t     pwr_o,
  output logic                  sleep_o,
  output logic                  core_clk_en_o,
  output logic [31:0]           status_o,
  output logic [31:0]           debug_o
);
  import cps_pkg::*;

  // ********************
  // state
  // ********************
  cps_state_t st;
  cps_state_t next_st;
  logic       wake;

  // majority-free three stage sync; change counts once s2 and s3 agree
  always_comb begin
    wake = (st.irq_s2 == st.irq_s3) && (st.irq_s3 != 3'h0);
  end

  always_comb begin
    next_st        = st;
    next_st.irq_s1 = {|wake_i.irq, wake_i.nmi, soft_reset_i};
    next_st.irq_s2 = st.irq_s1;
    next_st.irq_s3 = st.irq_s2;
    if (st.mode == CPS_RUN) begin
      if (status_we_i) next_st.status = status_wdata_i;
      if (debug_we_i) next_st.debug = debug_wdata_i;
      // hardware set wins over software write
      if (take_exl_i) next_st.status[`CPS_EXL_POS] = 1'b1;
      if (take_erl_i) next_st.status[`CPS_ERL_POS] = 1'b1;
      if (take_dbg_i) next_st.debug[`CPS_DM_POS] = 1'b1;
    end
    case (st.mode)
      CPS_RUN: begin
        if (wait_exec_i) next_st.mode = CPS_SLEEP;
      end
      CPS_SLEEP: begin
        if (wake) next_st.mode = CPS_RUN;
      end
      default: next_st.mode = CPS_RUN;
    endcase
  end

  // plain flops only, nothing dynamic, so a stopped clock holds state
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st.mode   <= CPS_RUN;
      st.status <= `CPS_STATUS_RST;
      st.debug  <= `CPS_DEBUG_RST;
      st.irq_s1 <= 3'h0;
      st.irq_s2 <= 3'h0;
      st.irq_s3 <= 3'h0;
    end else begin
      st <= next_st;
    end
  end

  // ********************
  // outputs
  // ********************
  always_comb begin
    pwr_o.low_power_request_out = st.status[`CPS_RP_POS];
    pwr_o.exception_level_out   = st.status[`CPS_EXL_POS];
    pwr_o.error_level_out       = st.status[`CPS_ERL_POS];
    pwr_o.debug_mode_out        = st.debug[`CPS_DM_POS];
    sleep_o       = (st.mode == CPS_SLEEP);
    // enable for an external clock gate; sync and this block keep running
    core_clk_en_o = (st.mode == CPS_RUN);
    status_o      = st.status;
    debug_o       = st.debug;
  end

  // ********************
  // checks
  // ********************
  rp_track_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pwr_o.low_power_request_out == status_o[`CPS_RP_POS]) else $error("rp output mismatch");

  exl_track_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pwr_o.exception_level_out == status_o[`CPS_EXL_POS])
    else $error("exl output mismatch");

  erl_track_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pwr_o.error_level_out == status_o[`CPS_ERL_POS])
    else $error("erl output mismatch");

  dm_track_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    pwr_o.debug_mode_out == debug_o[`CPS_DM_POS])
    else $error("dm output mismatch");

  exl_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (take_exl_i && !sleep_o) |=> pwr_o.exception_level_out) else $error("exl not set");
  erl_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (take_erl_i && !sleep_o) |=> pwr_o.error_level_out) else $error("erl not set");
  dm_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (take_dbg_i && !sleep_o) |=> pwr_o.debug_mode_out) else $error("dm not set");

  // writes and takes are refused while the core clock is stopped
  status_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && (status_we_i || take_exl_i || take_erl_i)) |=> $stable(status_o))
    else $error("status written in sleep");

  debug_refuse_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && (debug_we_i || take_dbg_i)) |=> $stable(debug_o))
    else $error("debug written in sleep");

  debug_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (debug_we_i && !take_dbg_i && !sleep_o) |=> pwr_o.debug_mode_out == $past(debug_wdata_i[`CPS_DM_POS]))
    else $error("dm write lost");

  rp_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (status_we_i && !sleep_o) |=> pwr_o.low_power_request_out == $past(status_wdata_i[`CPS_RP_POS]))
    else $error("rp write lost");

  // sync chain must shift one stage per edge, or wake timing drifts
  sync_shift_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (st.irq_s2 == $past(st.irq_s1)) && (st.irq_s3 == $past(st.irq_s2)))
    else $error("wake sync chain broken");

  irq_wake_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && (|wake_i.irq)) [*4] |=> !sleep_o) else $error("irq did not wake");

  srst_wake_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && soft_reset_i) [*4] |=> !sleep_o) else $error("soft reset did not wake");
  exl_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (status_we_i && !take_exl_i && !sleep_o) |=> pwr_o.exception_level_out == $past(status_wdata_i[`CPS_EXL_POS]))
    else $error("exl write lost");
  sleep_enter_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (wait_exec_i && !sleep_o) |=> sleep_o) else $error("sleep not entered");
  sleep_wake_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && wake_i.nmi) [*4] |=> !sleep_o) else $error("nmi did not wake");
  sleep_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && !wake) |=> sleep_o) else $error("sleep left without wake");
  gate_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    core_clk_en_o == !sleep_o) else $error("clock enable wrong");
  frozen_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (sleep_o && $past(sleep_o)) |-> $stable(status_o)) else $error("status moved in sleep");
endmodule : cps_core

// [verification/cps_agent.sv]
// Purpose: external power agent model
// Assumes: level outputs of cps_core
// Notes:   slows the system only while no level bit is up
`timescale 1ns/1ps
module cps_agent (
  input  wire cps_pkg::cps_pwr_t pwr_i,
  output logic                   slow_o
);
  import cps_pkg::*;
  // a pending exception must win, or it is serviced at the slow rate
  assign slow_o = pwr_i.low_power_request_out &
    ~(pwr_i.exception_level_out | pwr_i.error_level_out | pwr_i.debug_mode_out);
endmodule : cps_agent

// [verification/cps_core_tb.sv]
// Purpose: self-checking bench for cps_core
// Assumes: 10 MHz clock
// Notes:   ops are {status_we, debug_we, exl, erl, dbg, wait}
`timescale 1ns/1ps
module cps_core_tb;
  import cps_pkg::*;
  logic clk_sys_i = 0, arst_n_i = 0, swe = 0, dwe = 0, tx = 0, tr = 0, td = 0, wt = 0, srst = 0, sl, ce, slow;
  logic [31:0] d = '0, st, dg;
  cps_wake_t wk = '0;
  cps_pwr_t pw;
  int fail_count = 0, checks_done = 0;
  logic [35:0] rows [4] = '{{32'h0800_0000, 4'h8}, {32'h0800_0002, 4'hc}, {32'h0000_0004, 4'h2},
    {32'hf7ff_fff9, 4'h0}};
  cps_core dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .status_we_i(swe), .status_wdata_i(d),
    .debug_we_i(dwe), .debug_wdata_i(d), .take_exl_i(tx), .take_erl_i(tr), .take_dbg_i(td),
    .wait_exec_i(wt), .wake_i(wk), .soft_reset_i(srst), .pwr_o(pw), .sleep_o(sl),
    .core_clk_en_o(ce), .status_o(st), .debug_o(dg));
  cps_agent agent (.pwr_i(pw), .slow_o(slow));
  initial forever #50 clk_sys_i = ~clk_sys_i;
  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic op(input logic [5:0] c, input logic [31:0] v);
    @(posedge clk_sys_i) {swe, dwe, tx, tr, td, wt} <= c;
    d <= v;
    @(posedge clk_sys_i) {swe, dwe, tx, tr, td, wt} <= '0;
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask : op
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk_sys_i);
    cmp({pw, sl, ce, st}, {6'b001001, 32'h0040_0004});
    arst_n_i <= 1;
    foreach (rows[i]) begin
      op(6'b100000, rows[i][35:4]);
      cmp({pw, slow}, {rows[i][3:0], rows[i][3] & ~|rows[i][2:0]});
    end
    // takes land in the same cycle as a write and must win
    op(6'b101110, 32'h0800_0000);
    cmp({dg, st, pw}, {64'h4000_0000_0800_0006, 4'hf});
    op(6'b010000, '0);
    cmp(pw, 4'he);
    op(6'b000001, '0);
    cmp({sl, ce}, 2'b10);
    op(6'b100000, '0);
    cmp(st, 32'h0800_0006);
    for (int n = 0; n < 8; n++) begin
      if (n > 0) op(6'b000001, '0);
      cmp({sl, ce}, 2'b10);
      @(posedge clk_sys_i) {srst, wk} <= 8'h01 << n;
      for (int k = 0; k < 10 && sl; k++) @(negedge clk_sys_i);
      cmp({sl, ce}, 2'b01);
      if (sl !== 1'b0) test_done();
      @(posedge clk_sys_i) {srst, wk} <= '0;
    end
    // reset in mid-sleep must clear sleep and reload the words
    op(6'b000001, '0);
    cmp(sl, 1'b1);
    @(posedge clk_sys_i) arst_n_i <= 0;
    @(negedge clk_sys_i) cmp({pw, sl, ce, dg, st}, {6'b001001, 64'h0040_0004});
    @(posedge clk_sys_i) arst_n_i <= 1;
    op(6'b100000, 32'h0800_0000);
    cmp({pw, sl, st}, {4'h8, 1'b0, 32'h0800_0000});
    test_done();
  end
endmodule : cps_core_tb
